// ==== verilog/iee_pkg.sv ====
// Shared constants and types of the serial EEPROM slave front end
package iee_pkg;
    // Clock rate and write cycle time
    localparam int          CLK_MHZ      = 250;
    localparam int          T_WRITE_MS   = 5;
    // Longest write time in whole cycles
    localparam int          WRITE_CYC    = T_WRITE_MS * 1000 * CLK_MHZ;
    // Cycles a line must hold a new level before it is believed
    localparam int          GLITCH_CYC   = 2;
    // Array geometry
    localparam int          ARRAY_BYTES  = 512;
    localparam int          PAGE_BYTES   = 16;
    localparam int          ADDR_W       = 9;
    localparam int          PAGE_W       = 4;
    // Select byte field positions
    localparam int          SEL_TYPE_MSB = 7;
    localparam int          SEL_TYPE_LSB = 4;
    localparam int          SEL_HI_BIT   = 3;
    localparam int          SEL_LO_BIT   = 2;
    localparam int          SEL_TOP_BIT  = 1;
    localparam int          SEL_DIR_BIT  = 0;
    // Type field default; the value is arbitrary
    localparam logic [3:0]  TYPE_ID_DFLT = 4'hB;
    // Reset value of every array byte
    localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
    // Bit slot counts
    localparam logic [3:0]  BYTE_BITS    = 4'h8;
    localparam logic [3:0]  TENTH_SLOT   = 4'h1;

    // Byte level states
    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_DEVSEL = 3'b001,
        S_ADDR   = 3'b010,
        S_WDATA  = 3'b011,
        S_ACK    = 3'b100,
        S_RDATA  = 3'b101,
        S_RACK   = 3'b110
    } iee_state_t;
endpackage : iee_pkg

// ==== verilog/iee_line_if.sv ====
// Filtered bus line levels and events passed from the sampler to the slave
`timescale 1ns/1ps
interface iee_line_if;
    logic scl;       // Filtered clock level
    logic sda;       // Filtered data level
    logic scl_rise;  // One-cycle clock rising edge
    logic scl_fall;  // One-cycle clock falling edge
    logic start;     // One-cycle Start
    logic stop;      // One-cycle Stop
    modport drv (output scl, sda, scl_rise, scl_fall, start, stop);
    modport mon (input  scl, sda, scl_rise, scl_fall, start, stop);
endinterface : iee_line_if

// ==== verilog/iee_line_sync.sv ====
// Synchroniser, deglitch filter and Start/Stop detector for the bus lines
`timescale 1ns/1ps
module iee_line_sync
    import iee_pkg::*;
#(
    parameter int GLITCH = GLITCH_CYC
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    // Raw pins
    input  wire logic scl_i,
    input  wire logic sda_i,
    // Filtered levels and events
    iee_line_if.drv   line
);
    typedef struct packed {
        logic [1:0] s1;    // First sync stage, clock then data
        logic [1:0] s2;    // Second sync stage
        logic [1:0] filt;  // Filtered levels
        logic [3:0] c_cnt; // Clock stability count
        logic [3:0] d_cnt; // Data stability count
        logic [3:0] ev;    // Events: rise, fall, start, stop
    } iee_sync_t;

    iee_sync_t st_r;  // Registered state
    iee_sync_t st_nxt; // Next state

    localparam logic [3:0] GL_LAST = 4'(GLITCH - 1);

    // Filter each line, then find its edges and the bus conditions
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = {scl_i, sda_i};
        st_nxt.s2 = st_r.s1;
        if (st_r.s2[1] != st_r.filt[1]) begin
            st_nxt.c_cnt = st_r.c_cnt + 4'h1;
            if (st_r.c_cnt == GL_LAST) begin
                st_nxt.filt[1] = st_r.s2[1];
                st_nxt.c_cnt   = 4'h0;
            end
        end else begin
            st_nxt.c_cnt = 4'h0;
        end
        if (st_r.s2[0] != st_r.filt[0]) begin
            st_nxt.d_cnt = st_r.d_cnt + 4'h1;
            if (st_r.d_cnt == GL_LAST) begin
                st_nxt.filt[0] = st_r.s2[0];
                st_nxt.d_cnt   = 4'h0;
            end
        end else begin
            st_nxt.d_cnt = 4'h0;
        end
        st_nxt.ev[3] = st_nxt.filt[1] & ~st_r.filt[1];
        st_nxt.ev[2] = ~st_nxt.filt[1] & st_r.filt[1];
        st_nxt.ev[1] = st_r.filt[1] & st_nxt.filt[1] & st_r.filt[0] & ~st_nxt.filt[0];
        st_nxt.ev[0] = st_r.filt[1] & st_nxt.filt[1] & ~st_r.filt[0] & st_nxt.filt[0];
    end

    // Idle bus is high on both lines, so the filter starts there
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '{s1: 2'h3, s2: 2'h3, filt: 2'h3, c_cnt: 4'h0, d_cnt: 4'h0, ev: 4'h0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign line.scl      = st_r.filt[1];
    assign line.sda      = st_r.filt[0];
    assign line.scl_rise = st_r.ev[3];
    assign line.scl_fall = st_r.ev[2];
    assign line.start    = st_r.ev[1];
    assign line.stop     = st_r.ev[0];

    start_scl_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        line.start |-> line.scl && !line.sda) else $error("start seen without clock high");
endmodule : iee_line_sync

// ==== verilog/iee_wr_timer.sv ====
// Internal write cycle timer
`timescale 1ns/1ps
module iee_wr_timer #(
    parameter int CYCLES = 1250000
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    // Launch pulse and busy level
    input  wire logic launch_i,
    output logic      busy_o
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_r; // Cycles spent in the write

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_o <= 1'b0;
            cnt_r  <= '0;
        end else if (!busy_o) begin
            busy_o <= launch_i;
            cnt_r  <= '0;
        end else if (cnt_r == LAST) begin
            busy_o <= 1'b0;
        end else begin
            cnt_r <= cnt_r + CW'(1);
        end
    end

    wr_bound_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        busy_o |-> cnt_r <= LAST) else $error("write cycle overran");
endmodule : iee_wr_timer

// ==== verilog/iee_slave.sv ====
// Serial EEPROM slave: byte engine, select decode, page buffer and array
`timescale 1ns/1ps
module iee_slave
    import iee_pkg::*;
#(
    parameter logic [3:0] TYPE_ID      = TYPE_ID_DFLT, // Arbitrary type field value
    parameter int         WRITE_CYCLES = WRITE_CYC,
    parameter int         GLITCH       = GLITCH_CYC
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    // Serial bus pins
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_o,
    // Strap and protect pins
    input  wire logic strap_select_high_bit_i,
    input  wire logic strap_select_low_bit_i,
    input  wire logic write_protect_input_i,
    // Status
    output logic      write_busy_o,
    output logic      standby_o
);
    // All engine state in one record
    typedef struct packed {
        iee_state_t        state;   // Byte level state
        iee_state_t        after;   // State that follows an ack slot
        logic [3:0]        bit_cnt; // Bits seen in this byte
        logic [7:0]        shreg;   // Shift register, MSB first
        logic [ADDR_W-1:0] addr;    // Address counter
        logic              acked;   // Master acked a read byte
        logic              sda_oe;  // Pull the data line low
        logic              standby; // Standby indication
        logic              launch;  // Write cycle launch pulse
        logic [PAGE_BYTES-1:0]   bvalid; // Page buffer byte valid
        logic [PAGE_BYTES*8-1:0] pbuf;   // Page buffer data
        logic [2:0]        pin_s1;  // First sync stage of static pins
        logic [2:0]        pin_s2;  // Second sync stage of static pins
    } iee_st_t;

    iee_st_t   st_r;   // Registered state
    iee_st_t   st_nxt; // Next state
    logic      busy;   // Write cycle running
    logic [7:0] mem_r [ARRAY_BYTES]; // Storage array
    logic [ADDR_W-PAGE_W-1:0] page_r; // Page being committed

    iee_line_if line ();

    // Line sampler and Start/Stop detector
    iee_line_sync #(
        .GLITCH (GLITCH)
    ) u_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .line    (line)
    );

    // Write cycle timer
    iee_wr_timer #(
        .CYCLES (WRITE_CYCLES)
    ) u_timer (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .launch_i (st_r.launch),
        .busy_o   (busy)
    );

    // Synchronised static pins
    // Straps and protect read low from reset until their level is synced
    logic strap_hi;
    logic strap_lo;
    logic wp;
    assign strap_hi = st_r.pin_s2[2];
    assign strap_lo = st_r.pin_s2[1];
    assign wp       = st_r.pin_s2[0];

    // Does a select byte name this device
    function automatic logic sel_match(input logic [7:0] b, input logic hi, input logic lo);
        sel_match = (b[SEL_TYPE_MSB:SEL_TYPE_LSB] == TYPE_ID)
                  && (b[SEL_HI_BIT] == hi) && (b[SEL_LO_BIT] == lo);
    endfunction : sel_match

    // Next address inside the same page
    function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
        page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 4'h1};
    endfunction : page_inc

    // Byte engine
    always_comb begin
        st_nxt        = st_r;
        st_nxt.pin_s1 = {strap_select_high_bit_i, strap_select_low_bit_i, write_protect_input_i};
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.launch = 1'b0;
        if (busy) begin
            st_nxt.state   = S_IDLE;
            st_nxt.sda_oe  = 1'b0;
            st_nxt.standby = 1'b0;
        end else if (line.stop) begin
            if (st_r.state == S_WDATA && st_r.bit_cnt == TENTH_SLOT && st_r.bvalid != '0) begin
                st_nxt.launch = 1'b1;
            end
            st_nxt.state   = S_IDLE;
            st_nxt.sda_oe  = 1'b0;
            st_nxt.standby = ~st_nxt.launch;
        end else if (line.start) begin
            st_nxt.state   = S_DEVSEL;
            st_nxt.bit_cnt = 4'h0;
            st_nxt.sda_oe  = 1'b0;
            st_nxt.standby = 1'b0;
            st_nxt.bvalid  = '0;
        end else begin
            case (st_r.state)
                // Standby waits for a Start
                S_IDLE: begin
                    st_nxt.sda_oe = 1'b0;
                end
                // Select, address and write data bytes come in
                S_DEVSEL, S_ADDR, S_WDATA: begin
                    if (line.scl_rise) begin
                        st_nxt.shreg   = {st_r.shreg[6:0], line.sda};
                        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                    end else if (line.scl_fall && st_r.bit_cnt == BYTE_BITS) begin
                        st_nxt.bit_cnt = 4'h0;
                        st_nxt.state   = S_ACK;
                        st_nxt.sda_oe  = 1'b1;
                        if (st_r.state == S_DEVSEL) begin
                            if (sel_match(st_r.shreg, strap_hi, strap_lo)) begin
                                st_nxt.addr[ADDR_W-1] = st_r.shreg[SEL_TOP_BIT];
                                st_nxt.after = st_r.shreg[SEL_DIR_BIT] ? S_RDATA : S_ADDR;
                            end else begin
                                st_nxt.state   = S_IDLE;
                                st_nxt.sda_oe  = 1'b0;
                                st_nxt.standby = 1'b1;
                            end
                        end else if (st_r.state == S_ADDR) begin
                            st_nxt.addr[7:0] = st_r.shreg;
                            st_nxt.after     = S_WDATA;
                        end else begin
                            st_nxt.after = S_WDATA;
                            if (wp) begin
                                st_nxt.sda_oe = 1'b0;
                            end else begin
                                st_nxt.pbuf[st_r.addr[PAGE_W-1:0]*8 +: 8] = st_r.shreg;
                                st_nxt.bvalid[st_r.addr[PAGE_W-1:0]]      = 1'b1;
                                st_nxt.addr = page_inc(st_r.addr);
                            end
                        end
                    end
                end
                // Ninth slot ends at the clock fall
                S_ACK: begin
                    if (line.scl_fall) begin
                        st_nxt.sda_oe = 1'b0;
                        st_nxt.state  = st_r.after;
                        if (st_r.after == S_RDATA) begin
                            st_nxt.shreg  = mem_r[st_r.addr];
                            st_nxt.sda_oe = ~mem_r[st_r.addr][7];
                        end
                    end
                end
                // Read data goes out on clock falls
                S_RDATA: begin
                    if (line.scl_rise) begin
                        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                    end else if (line.scl_fall) begin
                        if (st_r.bit_cnt == BYTE_BITS) begin
                            st_nxt.sda_oe  = 1'b0;
                            st_nxt.bit_cnt = 4'h0;
                            st_nxt.acked   = 1'b0;
                            st_nxt.state   = S_RACK;
                            st_nxt.addr    = st_r.addr + 9'h001;
                        end else begin
                            // Next bit on the clock fall
                            st_nxt.shreg  = {st_r.shreg[6:0], 1'b0};
                            st_nxt.sda_oe = ~st_r.shreg[6];
                        end
                    end
                end
                // Master ack slot after a read byte
                S_RACK: begin
                    if (line.scl_rise) begin
                        if (line.sda) begin
                            st_nxt.state   = S_IDLE;
                            st_nxt.standby = 1'b1;
                        end else begin
                            st_nxt.acked = 1'b1;
                        end
                    end else if (line.scl_fall && st_r.acked) begin
                        st_nxt.state  = S_RDATA;
                        st_nxt.shreg  = mem_r[st_r.addr];
                        st_nxt.sda_oe = ~mem_r[st_r.addr][7];
                    end
                end
                default: begin
                    st_nxt.state  = S_IDLE;
                    st_nxt.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // Reset puts the engine in standby
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '{state: S_IDLE, after: S_IDLE, bit_cnt: 4'h0, shreg: 8'h00,
                      addr: 9'h000, acked: 1'b0, sda_oe: 1'b0, standby: 1'b1,
                      launch: 1'b0, bvalid: 16'h0000, pbuf: '0,
                      pin_s1: 3'h0, pin_s2: 3'h0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Storage; the page buffer is committed when the write cycle launches
    assign page_r = st_r.addr[ADDR_W-1:PAGE_W];
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < ARRAY_BYTES; i++) begin
                mem_r[i] <= ERASED_BYTE;
            end
        end else if (st_r.launch) begin
            for (int j = 0; j < PAGE_BYTES; j++) begin
                if (st_r.bvalid[j]) begin
                    mem_r[{page_r, 4'(j)}] <= st_r.pbuf[j*8 +: 8];
                end
            end
        end
    end

    // Outputs straight from flip-flops; the data output level is always low
    // Target only, no clock driven
    assign sda_o        = 1'b0;
    assign sda_oe_o     = st_r.sda_oe;
    assign write_busy_o = busy;
    assign standby_o    = st_r.standby;

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence sel_end_s;
        st_r.state == S_DEVSEL && line.scl_fall && st_r.bit_cnt == BYTE_BITS && !busy && !line.stop;
    endsequence
    sequence tenth_stop_s;
        line.stop && !busy && st_r.state == S_WDATA && st_r.bit_cnt == TENTH_SLOT && st_r.bvalid != '0;
    endsequence

    busy_quiet_a: assert property (busy |-> !sda_oe_o) else $error("data driven while busy");
    sel_ack_a: assert property (sel_end_s and sel_match(st_r.shreg, strap_hi, strap_lo)
        |=> sda_oe_o && st_r.state == S_ACK) else $error("select match not acked");
    sel_miss_a: assert property (sel_end_s and !sel_match(st_r.shreg, strap_hi, strap_lo)
        |=> !sda_oe_o && standby_o) else $error("select mismatch not released");
    wp_nack_a: assert property (st_r.state == S_WDATA && line.scl_fall && st_r.bit_cnt == BYTE_BITS
        && wp && !busy && !line.stop && !line.start |=> !sda_oe_o && st_r.bvalid == $past(st_r.bvalid))
        else $error("protected data byte acked");
    launch_a: assert property (tenth_stop_s |=> ##1 busy) else $error("write not launched");
    no_launch_a: assert property (line.stop && !busy && !(st_r.state == S_WDATA
        && st_r.bit_cnt == TENTH_SLOT) |=> !st_r.launch) else $error("stray write launch");
    stop_idle_a: assert property (line.stop && !busy |=> st_r.state == S_IDLE && !sda_oe_o)
        else $error("stop did not end transfer");
    start_sel_a: assert property (line.start && !busy && !line.stop
        |=> st_r.state == S_DEVSEL && st_r.bit_cnt == 4'h0) else $error("start not taken");
    read_inc_a: assert property (st_r.state == S_RDATA && line.scl_fall && st_r.bit_cnt == BYTE_BITS
        && !busy && !line.stop && !line.start |=> st_r.addr == $past(st_r.addr) + 9'h001)
        else $error("read address not advanced");
    rnack_a: assert property (st_r.state == S_RACK && line.scl_rise && line.sda && !busy
        && !line.stop && !line.start |=> standby_o [*2]) else $error("read nack kept active");
endmodule : iee_slave

// ==== dv/iee_master.sv ====
// Bus master model: drives the serial clock and pulls the data wire low
`timescale 1ns/1ps
module iee_master (
    // Clock and resolved wire
    input  wire logic clock_i,
    input  wire logic sda_i,
    // Driven lines
    output logic      scl_o,
    output logic      sda_oe_o
);
    // Idle: clock high and still, data released
    initial begin
        scl_o    = 1'b1;
        sda_oe_o = 1'b0;
    end
    // Wait whole cycles, landing on a falling edge
    task automatic hold(input int n);
        repeat (n) @(negedge clock_i);
    endtask : hold
    // Master clocks, data moves while low
    // Long low phase lets the slave's late ack release settle first
    task automatic bit_x(input logic b, output logic r);
        scl_o = 1'b0;
        hold(3);
        sda_oe_o = ~b;
        hold(5);
        scl_o = 1'b1;
        hold(3);
        r = sda_i;
        hold(1);
    endtask : bit_x
    // Start when p is 0, Stop when p is 1
    task automatic cond(input logic p);
        // Data moves only after the clock fall has been seen, never with it
        scl_o = 1'b0;
        hold(3);
        sda_oe_o = p;
        hold(5);
        scl_o = 1'b1;
        hold(4);
        sda_oe_o = ~p;
        hold(4);
    endtask : cond
    // MSB first, ninth slot carries the ack
    task automatic xfer(input logic [7:0] d, input logic n, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(n, a);
    endtask : xfer
endmodule : iee_master

// ==== dv/test_iee_slave.sv ====
// Self-checking bench of the serial EEPROM slave front end
`timescale 1ns/1ps
module test_iee_slave
    import iee_pkg::*;
;
    logic       clock_i, rst_n_i, hi, lo, wp; // Clock, reset, strap and protect pins
    logic       sda_o, sda_oe, busy, stby;    // Design outputs
    logic       scl, m_oe;                    // Master lines
    wire        sda_w = ~(sda_oe | m_oe);     // Pulled-up open-drain wire
    logic [7:0] q;                            // Last byte seen
    logic       a;                            // Last ninth-slot level
    int         fails, tests_run;
    iee_slave #(.WRITE_CYCLES(200)) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .strap_select_high_bit_i(hi),
        .strap_select_low_bit_i(lo), .write_protect_input_i(wp), .write_busy_o(busy), .standby_o(stby));
    iee_master master_u (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(m_oe));
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    task automatic check(input logic [8:0] s, input logic [8:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check
    // Select byte for given straps, top address bit and direction
    function automatic logic [7:0] sb(input logic [1:0] st, input logic t, input logic d);
        return {TYPE_ID_DFLT, st, t, d};
    endfunction : sb
    task automatic go(input logic [7:0] d, input logic n);
        master_u.xfer(d, n, q, a);
    endtask : go
    // Dummy write, repeated Start, two reads (ack then nack), Stop
    task automatic rd(input logic [8:0] ad, input logic [7:0] e0, input logic [7:0] e1);
        master_u.cond(1'b0);
        go(sb(2'b10, ad[8], 1'b0), 1'b1);
        go(ad[7:0], 1'b1);
        master_u.cond(1'b0);
        go(sb(2'b10, ad[8], 1'b1), 1'b1);
        check(a, 1'b0);
        go(8'hFF, 1'b0);
        check(q, e0);
        go(8'hFF, 1'b1);
        check(q, e1);
        master_u.cond(1'b1);
        check(stby, 1'b1);
    endtask : rd
    // Page write of two bytes from 1FFh wraps to 1F0h, then polls
    task automatic t_write();
        master_u.cond(1'b0);
        go(sb(2'b10, 1'b1, 1'b0), 1'b1);
        check(a, 1'b0);
        go(8'hFF, 1'b1);
        go(8'hA5, 1'b1);
        go(8'h5A, 1'b1);
        check(a, 1'b0);
        master_u.cond(1'b1);
        master_u.hold(4);
        check(busy, 1'b1);
        master_u.cond(1'b0);
        go(sb(2'b10, 1'b1, 1'b0), 1'b1);
        check({a, sda_oe}, 2'b10);
        master_u.cond(1'b1);
        for (int i = 0; i < 400 && busy !== 1'b0; i++) master_u.hold(1);
        check(busy, 1'b0);
        rd(9'h1FF, 8'hA5, 8'hFF);
        rd(9'h1F0, 8'h5A, 8'hFF);
    endtask : t_write
    // Protected data nacked; early Stop and wrong straps launch nothing
    task automatic t_refuse();
        wp = 1'b1;
        master_u.cond(1'b0);
        go(sb(2'b10, 1'b1, 1'b0), 1'b1);
        check(a, 1'b0);
        go(8'hF0, 1'b1);
        check(a, 1'b0);
        go(8'h00, 1'b1);
        check(a, 1'b1);
        master_u.cond(1'b1);
        wp = 1'b0;
        master_u.cond(1'b0);
        go(sb(2'b10, 1'b1, 1'b0), 1'b1);
        go(8'hF0, 1'b1);
        master_u.cond(1'b1);
        master_u.hold(8);
        check(busy, 1'b0);
        master_u.cond(1'b0);
        go(sb(2'b01, 1'b1, 1'b0), 1'b1);
        check(a, 1'b1);
        master_u.cond(1'b1);
        rd(9'h1F0, 8'h5A, 8'hFF);
    endtask : t_refuse
    // Swapped straps answer their own code; straps both driven low answer zero, zero
    task automatic t_straps();
        hi = 1'b0;
        lo = 1'b1;
        master_u.hold(4);
        master_u.cond(1'b0);
        go(sb(2'b10, 1'b1, 1'b1), 1'b1);
        check(a, 1'b1);
        master_u.cond(1'b1);
        master_u.cond(1'b0);
        go(sb(2'b01, 1'b1, 1'b1), 1'b1);
        check(a, 1'b0);
        go(8'hFF, 1'b1);
        check(q, 8'hFF);
        master_u.cond(1'b1);
        lo = 1'b0;
        master_u.hold(4);
        master_u.cond(1'b0);
        go(sb(2'b00, 1'b1, 1'b1), 1'b1);
        check(a, 1'b0);
        go(8'hFF, 1'b1);
        master_u.cond(1'b1);
        check(stby, 1'b1);
    endtask : t_straps
    task automatic complete_run();
        if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    // Watchdog well past the expected run of a few thousand cycles
    initial begin
        #100000;
        fails++;
        complete_run();
    end
    initial begin
        {rst_n_i, hi, lo, wp} = 4'h8 - 4'h8;
        fails = 0;
        tests_run = 0;
        hi = 1'b1;
        master_u.hold(2);
        rst_n_i = 1'b1;
        master_u.hold(10);
        check({stby, busy, sda_oe, sda_o}, 4'h8);
        t_write();
        t_refuse();
        t_straps();
        complete_run();
    end
endmodule : test_iee_slave
